//--- src/smre_read_engine.sv
// Two-wire serial memory slave: read engine with address latch and array
// Notes on behaviour
// R1 - Reads take the low eight address bits from the internal latch.
// R2 - A current address read starts just after the last accessed location.
// R3 - The master requests a read with address byte bit zero set to one.
// R4 - The page bit in the address byte picks the 256-byte half.
// R5 - After acknowledging a read address, data goes out on the next clock.
// R6 - Read address is page bit above the eight latch bits.
// R7 - Unlimited bytes per read; the counter advances after every byte.
// R8 - A master acknowledge makes the next sequential byte follow.
// R9 - Master should end a read by no-acknowledge then STOP.
// R10 - No-acknowledge then START ends the read and begins a new command.
// R11 - STOP or START in the ninth clock stops driving and leaves the read.
// R12 - Master must end reads properly or the bus sees contention.
// R13 - After the top location the next byte comes from address zero.
// R14 - A write address byte then word byte loads the address latch.
// R15 - A repeated START abandons the write unstored and begins a read.
// R16 - Respond only when address bits three and two match the select pins.
// R17 - Latch increments after each data byte, before its acknowledge slot.
// R18 - All bytes travel most significant bit first.
// R19 - STOP aborts any operation and returns to idle.
// R20 - After a read ends, sda is released until addressed again.
// R21 - The address latch survives STOP for later current address reads.
module smre_read_engine
  import smre_pkg::*;
#(
  // Arbitrary slave id value
  parameter logic [3:0] DEV_ID = 4'h5
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  // Two-wire bus
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda,
  output logic            o_sda_oe,
  // Device select straps
  input  wire logic [1:0] i_chip_select_pins
);
  logic                    scl_rise;
  logic                    scl_fall;
  logic                    bus_start;
  logic                    bus_stop;
  logic                    sda_s;
  smre_state_t             state_ff;
  logic [3:0]              bit_ff;
  logic [7:0]              shift_ff;
  logic [7:0]              latch_ff;
  logic                    page_ff;
  logic                    rw_ff;
  logic                    ack_ff;
  logic                    drive_low_ff;
  logic [7:0]              mem [SMRE_DEPTH];
  logic [SMRE_ADDR_W-1:0]  cur_addr;
  logic [SMRE_ADDR_W-1:0]  nxt_addr;
  logic [7:0]              rd_byte;
  logic                    id_match;
  logic                    cs_match;
  logic [1:0]              cs_meta_ff;
  logic [1:0]              cs_ff;

  smre_pin_sync u_sync (
    .i_clk      (i_clk),
    .i_rst_b    (i_rst_b),
    .i_scl      (i_scl),
    .i_sda      (i_sda),
    .o_scl_rise (scl_rise),
    .o_scl_fall (scl_fall),
    .o_start    (bus_start),
    .o_stop     (bus_stop),
    .o_sda      (sda_s)
  );

  // Straps come from pins, so they are synchronised too
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      cs_meta_ff <= 2'h0;
      cs_ff      <= 2'h0;
    end else begin
      cs_meta_ff <= i_chip_select_pins;
      cs_ff      <= cs_meta_ff;
    end
  end

  assign cur_addr = {page_ff, latch_ff};                        // R6
  assign nxt_addr = cur_addr + SMRE_ADDR_STEP;                  // R13
  assign rd_byte  = mem[cur_addr];                              // R1
  assign id_match = shift_ff[SMRE_ID_HI:SMRE_ID_LO] == DEV_ID;
  assign cs_match = shift_ff[SMRE_CS_HI:SMRE_CS_LO] == cs_ff;   // R16

  // Bus sequencing
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      state_ff <= SMRE_IDLE;
    end else if (bus_stop) begin
      state_ff <= SMRE_IDLE;                                    // R19
    end else if (bus_start) begin
      state_ff <= SMRE_ADDR;                                    // R10 R11 R15
    end else if (scl_fall) begin
      unique case (state_ff)
        SMRE_IDLE: begin
          state_ff <= SMRE_IDLE;
        end
        SMRE_ADDR: begin
          if (bit_ff == SMRE_BIT_FULL) begin
            state_ff <= (id_match && cs_match) ? SMRE_ADDR_ACK
                                               : SMRE_IDLE;     // R16
          end
        end
        SMRE_ADDR_ACK: begin
          state_ff <= rw_ff ? SMRE_RDATA : SMRE_WORD;           // R3 R5
        end
        SMRE_WORD: begin
          if (bit_ff == SMRE_BIT_FULL) begin
            state_ff <= SMRE_WORD_ACK;
          end
        end
        SMRE_WORD_ACK: begin
          state_ff <= SMRE_WDATA;
        end
        SMRE_WDATA: begin
          if (bit_ff == SMRE_BIT_FULL) begin
            state_ff <= SMRE_WDAT_ACK;
          end
        end
        SMRE_WDAT_ACK: begin
          state_ff <= SMRE_WDATA;
        end
        SMRE_RDATA: begin
          if (bit_ff == SMRE_BIT_LAST) begin
            state_ff <= SMRE_RACK;
          end
        end
        SMRE_RACK: begin
          state_ff <= ack_ff ? SMRE_RDATA : SMRE_IDLE;          // R8 R20
        end
        default: begin
          state_ff <= SMRE_IDLE;
        end
      endcase
    end
  end

  // Bit counter and shift register, shared by receive and transmit
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      bit_ff   <= SMRE_BIT_RST;
      shift_ff <= SMRE_BYTE_RST;
    end else if (bus_start || bus_stop) begin
      bit_ff   <= SMRE_BIT_RST;
    end else if (scl_rise && (state_ff == SMRE_ADDR ||
                 state_ff == SMRE_WORD || state_ff == SMRE_WDATA)) begin
      shift_ff <= {shift_ff[6:0], sda_s};                       // R18
      bit_ff   <= bit_ff + 4'h1;
    end else if (scl_fall) begin
      if ((state_ff == SMRE_ADDR_ACK && rw_ff) ||
          (state_ff == SMRE_RACK && ack_ff)) begin
        shift_ff <= rd_byte;                                    // R5 R8
        bit_ff   <= SMRE_BIT_RST;
      end else if (state_ff == SMRE_RDATA) begin
        shift_ff <= {shift_ff[6:0], 1'b0};                      // R18
        bit_ff   <= bit_ff + 4'h1;
      end else if (bit_ff == SMRE_BIT_FULL || state_ff == SMRE_ADDR_ACK) begin
        bit_ff   <= SMRE_BIT_RST;
      end
    end
  end

  // Address byte fields; page is taken per access
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      rw_ff <= 1'b0;
    end else if (scl_fall && state_ff == SMRE_ADDR &&
                 bit_ff == SMRE_BIT_FULL) begin
      rw_ff <= shift_ff[SMRE_RW_BIT];                           // R3
    end
  end

  // Address latch: kept across STOP and START, advanced per byte
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      latch_ff <= SMRE_ADDR_RST[7:0];
      page_ff  <= 1'b0;
    end else if (scl_fall && !bus_start && !bus_stop) begin      // R21
      if (state_ff == SMRE_ADDR && bit_ff == SMRE_BIT_FULL &&
          id_match && cs_match) begin
        page_ff  <= shift_ff[SMRE_PAGE_BIT];                    // R4
      end else if (state_ff == SMRE_WORD && bit_ff == SMRE_BIT_FULL) begin
        latch_ff <= shift_ff;                                   // R14
      end else if ((state_ff == SMRE_WDATA && bit_ff == SMRE_BIT_FULL) ||
                   (state_ff == SMRE_RDATA && bit_ff == SMRE_BIT_LAST)) begin
        {page_ff, latch_ff} <= nxt_addr;                        // R2 R7 R13 R17
      end
    end
  end

  // Array write only once all eight data bits are in
  always_ff @(posedge i_clk) begin
    if (scl_fall && !bus_start && !bus_stop &&
        state_ff == SMRE_WDATA && bit_ff == SMRE_BIT_FULL) begin
      mem[cur_addr] <= shift_ff;                                // R15
    end
  end

  // Master acknowledge in the ninth clock
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      ack_ff <= 1'b0;
    end else if (scl_rise && state_ff == SMRE_RACK) begin
      ack_ff <= ~sda_s;
    end else if (bus_start || bus_stop) begin
      ack_ff <= 1'b0;
    end
  end

  // Sda driver: pulls low for acks and zero data bits, else released
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      drive_low_ff <= 1'b0;
    end else if (bus_start || bus_stop) begin
      drive_low_ff <= 1'b0;                                     // R11 R19
    end else if (scl_fall) begin
      unique case (state_ff)
        SMRE_ADDR: begin
          drive_low_ff <= bit_ff == SMRE_BIT_FULL && id_match &&
                          cs_match;                             // R16
        end
        SMRE_WORD, SMRE_WDATA: begin
          drive_low_ff <= bit_ff == SMRE_BIT_FULL;
        end
        SMRE_ADDR_ACK: begin
          drive_low_ff <= rw_ff && !rd_byte[7];                 // R5
        end
        SMRE_RDATA: begin
          // Release for the master's acknowledge slot
          drive_low_ff <= bit_ff != SMRE_BIT_LAST && !shift_ff[6];
        end
        SMRE_RACK: begin
          // Without an ack the master may send STOP, so stay off
          drive_low_ff <= ack_ff && !rd_byte[7];                // R8 R20
        end
        default: begin
          drive_low_ff <= 1'b0;
        end
      endcase
    end
  end

  // Open-drain: only ever drives a zero
  assign o_sda    = 1'b0;
  assign o_sda_oe = drive_low_ff;

  a_stop_to_idle: assert property (                             // R19
    @(posedge i_clk) disable iff (!i_rst_b)
    bus_stop |=> state_ff == SMRE_IDLE && !o_sda_oe)
    else $error("stop did not return to idle");

  a_start_leaves: assert property (                             // R11
    @(posedge i_clk) disable iff (!i_rst_b)
    bus_start && !bus_stop |=> state_ff == SMRE_ADDR && !o_sda_oe)
    else $error("start did not release the bus");

  a_latch_kept: assert property (                               // R21
    @(posedge i_clk) disable iff (!i_rst_b)
    bus_stop |=> $stable(latch_ff) && $stable(page_ff))
    else $error("address latch lost at stop");

  a_wrap_zero: assert property (                                // R13
    @(posedge i_clk) disable iff (!i_rst_b)
    scl_fall && !bus_start && !bus_stop && state_ff == SMRE_RDATA &&
    bit_ff == SMRE_BIT_LAST && cur_addr == SMRE_ADDR_TOP
    |=> cur_addr == SMRE_ADDR_RST)
    else $error("address did not wrap to zero");

  a_word_load: assert property (                                // R14
    @(posedge i_clk) disable iff (!i_rst_b)
    scl_fall && !bus_start && !bus_stop && state_ff == SMRE_WORD &&
    bit_ff == SMRE_BIT_FULL |=> latch_ff == $past(shift_ff))
    else $error("word address not latched");

  a_cs_mismatch: assert property (                              // R16
    @(posedge i_clk) disable iff (!i_rst_b)
    scl_fall && !bus_start && !bus_stop && state_ff == SMRE_ADDR &&
    bit_ff == SMRE_BIT_FULL && !cs_match
    |=> state_ff == SMRE_IDLE && !o_sda_oe)
    else $error("answered a foreign select address");

  a_read_first_bit: assert property (                           // R5
    @(posedge i_clk) disable iff (!i_rst_b)
    scl_fall && !bus_start && !bus_stop && state_ff == SMRE_ADDR_ACK &&
    rw_ff |=> state_ff == SMRE_RDATA && o_sda_oe == !$past(rd_byte[7]))
    else $error("read data did not start after address ack");

  a_nack_release: assert property (                             // R20
    @(posedge i_clk) disable iff (!i_rst_b)
    scl_fall && !bus_start && !bus_stop && state_ff == SMRE_RACK &&
    !ack_ff |=> state_ff == SMRE_IDLE && !o_sda_oe
    ##1 (!o_sda_oe throughout (state_ff == SMRE_IDLE)[*3]))
    else $error("bus not released after no-acknowledge");

  a_ack_next: assert property (                                 // R8
    @(posedge i_clk) disable iff (!i_rst_b)
    scl_fall && !bus_start && !bus_stop && state_ff == SMRE_RACK &&
    ack_ff |=> state_ff == SMRE_RDATA && bit_ff == SMRE_BIT_RST)
    else $error("acknowledged read did not continue");

  a_count_step: assert property (                               // R17
    @(posedge i_clk) disable iff (!i_rst_b)
    scl_fall && !bus_start && !bus_stop && state_ff == SMRE_RDATA &&
    bit_ff == SMRE_BIT_LAST
    |=> state_ff == SMRE_RACK && cur_addr == $past(nxt_addr) &&
        !o_sda_oe)
    else $error("counter not advanced before ack slot");
endmodule : smre_read_engine

//--- src/smre_pkg.sv
// Package with constants and types for the serial memory read engine
package smre_pkg;
  localparam int          SMRE_ADDR_W      = 9;
  localparam int          SMRE_DEPTH       = 512;
  localparam int          SMRE_BYTE_BITS   = 8;
  localparam logic [3:0]  SMRE_BIT_LAST    = 4'h7;
  localparam logic [3:0]  SMRE_BIT_FULL    = 4'h8;
  localparam logic [3:0]  SMRE_BIT_RST     = 4'h0;
  localparam logic [8:0]  SMRE_ADDR_RST    = 9'h000;
  localparam logic [8:0]  SMRE_ADDR_TOP    = 9'h1FF;
  localparam logic [8:0]  SMRE_ADDR_STEP   = 9'h001;
  localparam logic [7:0]  SMRE_BYTE_RST    = 8'h00;
  // Slave id, select, page and read/write field positions in the address byte
  localparam int          SMRE_ID_HI       = 7;
  localparam int          SMRE_ID_LO       = 4;
  localparam int          SMRE_CS_HI       = 3;
  localparam int          SMRE_CS_LO       = 2;
  localparam int          SMRE_PAGE_BIT    = 1;
  localparam int          SMRE_RW_BIT      = 0;

  typedef enum logic [8:0] {
    SMRE_IDLE     = 9'b0_0000_0001,
    SMRE_ADDR     = 9'b0_0000_0010,
    SMRE_ADDR_ACK = 9'b0_0000_0100,
    SMRE_WORD     = 9'b0_0000_1000,
    SMRE_WORD_ACK = 9'b0_0001_0000,
    SMRE_WDATA    = 9'b0_0010_0000,
    SMRE_WDAT_ACK = 9'b0_0100_0000,
    SMRE_RDATA    = 9'b0_1000_0000,
    SMRE_RACK     = 9'b1_0000_0000
  } smre_state_t;
endpackage : smre_pkg

//--- src/smre_pin_sync.sv
// Two-flop synchronisers for the bus pins and bus event detection
module smre_pin_sync (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  // Raw pins
  input  wire logic i_scl,
  input  wire logic i_sda,
  // Bus events as one-cycle pulses, plus the synchronised sda level
  output logic      o_scl_rise,
  output logic      o_scl_fall,
  output logic      o_start,
  output logic      o_stop,
  output logic      o_sda
);
  logic [1:0] meta_ff;
  logic [1:0] sync_ff;
  logic [1:0] prev_ff;

  // Bit 1 is scl, bit 0 is sda; meta_ff feeds only sync_ff
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      meta_ff <= 2'h3;
      sync_ff <= 2'h3;
      prev_ff <= 2'h3;
    end else begin
      meta_ff <= {i_scl, i_sda};
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  assign o_scl_rise = sync_ff[1] & ~prev_ff[1];
  assign o_scl_fall = ~sync_ff[1] & prev_ff[1];
  // Sda edges only count while scl stays high
  assign o_start    = sync_ff[1] & prev_ff[1] & ~sync_ff[0] & prev_ff[0];
  assign o_stop     = sync_ff[1] & prev_ff[1] & sync_ff[0] & ~prev_ff[0];
  assign o_sda      = sync_ff[0];
endmodule : smre_pin_sync

//--- verif/smre_bus_master.sv
// Bus master model that clocks the two-wire bus from the system clock
module smre_bus_master (
  // Clock
  input  wire logic i_clk,
  // Resolved data line
  input  wire logic i_sda,
  // Bus drive, enable high pulls the data line low
  output logic      o_scl,
  output logic      o_sda_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int QTR = 4;  // Quarter of the 160 ns bus period
  initial begin
    o_scl    = 1'b1;
    o_sda_oe = 1'b0;
  end
  task automatic tick();
    repeat (QTR) @(posedge i_clk);
  endtask : tick
  // Data moves only while the bus clock is low; sampled mid high phase
  task automatic put_bit(input logic b, output logic got);
    tick();
    o_sda_oe <= ~b;
    tick();
    o_scl <= 1'b1;
    tick();
    got = i_sda;
    tick();
    o_scl <= 1'b0;
  endtask : put_bit
  task automatic start_cond();
    tick();
    o_sda_oe <= 1'b0;
    tick();
    o_scl <= 1'b1;
    tick();
    o_sda_oe <= 1'b1;
    tick();
    o_scl <= 1'b0;
  endtask : start_cond
  task automatic stop_cond();
    tick();
    o_sda_oe <= 1'b1;
    tick();
    o_scl <= 1'b1;
    tick();
    o_sda_oe <= 1'b0;
    tick();
  endtask : stop_cond
  // Sends the top n bits; a whole byte also gets its answer slot
  task automatic send_byte(input logic [7:0] d, input int n, output logic ack);
    logic b;
    ack = 1'b0;
    for (int i = 7; i > 7 - n; i--) begin
      put_bit(d[i], b);
    end
    if (n == 8) begin
      put_bit(1'b1, b);
      ack = ~b;
    end
  endtask : send_byte
  // Answer slot is left to the caller so it can end the read its own way
  task automatic recv_byte(output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, d[i]);
    end
  endtask : recv_byte
endmodule : smre_bus_master

//--- verif/smre_read_engine_test.sv
// Self-checking bench: bus master model against the read engine
module smre_read_engine_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] ID   = 4'h6;  // Arbitrary slave id value
  localparam logic [1:0] CSEL = 2'h2;
  logic       clk;
  logic       rst_b;
  logic       scl;
  logic       m_oe;
  logic       dev_sda;
  logic       dev_oe;
  logic       sda;
  logic [1:0] csel;
  logic [7:0] mem [512];
  logic [8:0] ptr;
  int         errors;
  int         check_count;
  // Open drain with pull-up: low while either side pulls
  assign sda = ~(m_oe | (dev_oe & ~dev_sda));
  smre_read_engine #(.DEV_ID(ID)) u_smre_read_engine (
    .i_clk              (clk),
    .i_rst_b            (rst_b),
    .i_scl              (scl),
    .i_sda              (sda),
    .o_sda              (dev_sda),
    .o_sda_oe           (dev_oe),
    .i_chip_select_pins (csel)
  );
  smre_bus_master u_smre_bus_master (
    .i_clk    (clk),
    .i_sda    (sda),
    .o_scl    (scl),
    .o_sda_oe (m_oe)
  );
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] want);
    check_count++;
    if (seen !== want) begin
      errors++;
      $display("Error %s expected %h seen %h", what, want, seen);
    end
  endtask : check
  task automatic summarize();
    if (errors == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize
  task automatic addr(input logic [1:0] cs, input logic page,
                      input logic rw, input logic want);
    logic ack;
    u_smre_bus_master.start_cond();
    u_smre_bus_master.send_byte({ID, cs, page, rw}, 8, ack);
    check("address ack", {7'h00, ack}, {7'h00, want});
  endtask : addr
  task automatic set_addr(input logic [8:0] a);
    logic ack;
    addr(CSEL, a[8], 1'b0, 1'b1);
    u_smre_bus_master.send_byte(a[7:0], 8, ack);
    check("word ack", {7'h00, ack}, 8'h01);
    ptr = a;
  endtask : set_addr
  task automatic wr_bytes(input logic [8:0] a, input logic [7:0] d[$]);
    logic ack;
    set_addr(a);
    foreach (d[i]) begin
      u_smre_bus_master.send_byte(d[i], 8, ack);
      check("data ack", {7'h00, ack}, 8'h01);
      mem[ptr] = d[i];
      ptr++;
    end
    u_smre_bus_master.stop_cond();
  endtask : wr_bytes
  // Acks every byte but the last; the caller ends the read
  task automatic rd(input logic page, input int n);
    logic [7:0] d;
    logic       line;
    ptr[8] = page;
    for (int i = 0; i < n; i++) begin
      u_smre_bus_master.recv_byte(d);
      check("read data", d, mem[ptr]);
      ptr++;
      if (i < n - 1) begin
        u_smre_bus_master.put_bit(1'b0, line);
      end
    end
  endtask : rd
  task automatic nack();
    logic line;
    u_smre_bus_master.put_bit(1'b1, line);
    check("nack line", {7'h00, line}, 8'h01);
  endtask : nack
  // A late release would clash with the master's next command
  task automatic idle_check();
    int hits;
    hits = 0;
    repeat (32) begin
      @(posedge clk);
      hits += int'(dev_oe !== 1'b0);
    end
    check("released", 8'(hits), 8'h00);
  endtask : idle_check
  task automatic sc_refuse();
    addr(~CSEL, 1'b0, 1'b1, 1'b0);
    u_smre_bus_master.stop_cond();
    // Moving the straps must move the answered address with them
    csel <= ~CSEL;
    addr(~CSEL, 1'b0, 1'b0, 1'b1);
    u_smre_bus_master.stop_cond();
    csel <= CSEL;
    idle_check();
  endtask : sc_refuse
  task automatic sc_wrap_read();
    wr_bytes(9'h1FE, '{8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hA4});
    set_addr(9'h1FE);
    addr(CSEL, 1'b1, 1'b1, 1'b1);
    rd(1'b1, 3);
    nack();
    u_smre_bus_master.stop_cond();
    idle_check();
  endtask : sc_wrap_read
  task automatic sc_current();
    addr(CSEL, 1'b0, 1'b1, 1'b1);
    rd(1'b0, 1);
    nack();
    addr(CSEL, 1'b0, 1'b1, 1'b1);
    rd(1'b0, 1);
    u_smre_bus_master.stop_cond();
    idle_check();
  endtask : sc_current
  task automatic sc_page();
    wr_bytes(9'h010, '{8'h55, 8'h66});
    wr_bytes(9'h110, '{8'hAA});
    set_addr(9'h010);
    addr(CSEL, 1'b1, 1'b1, 1'b1);
    rd(1'b1, 1);
    addr(CSEL, 1'b0, 1'b1, 1'b1);
    rd(1'b0, 1);
    nack();
    u_smre_bus_master.stop_cond();
  endtask : sc_page
  task automatic sc_abort();
    logic ack;
    set_addr(9'h010);
    u_smre_bus_master.send_byte(8'h99, 4, ack);
    u_smre_bus_master.stop_cond();
    addr(CSEL, 1'b0, 1'b1, 1'b1);
    rd(1'b0, 1);
    nack();
    u_smre_bus_master.stop_cond();
  endtask : sc_abort
  initial begin
    errors      = 0;
    check_count = 0;
    rst_b       = 1'b0;
    csel        = CSEL;
    ptr         = 9'h000;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    sc_refuse();
    sc_wrap_read();
    sc_current();
    sc_page();
    sc_abort();
    summarize();
  end
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    summarize();
  end
endmodule : smre_read_engine_test
